// File: common/mps_pkg.sv
// Shared constants and carrier types for the motor protection scan and supervision block.
// Assumes a single 50 MHz system clock and a line-cycle strobe from outside.
package mps_pkg;
    // Clock and supervision timing
    localparam int CLK_HZ = 50000000;
    localparam int WDOG_TIMEOUT_MS = 250;
    localparam int WDOG_CYCLES = CLK_HZ / 1000 * WDOG_TIMEOUT_MS;
    localparam int RST_PULSE_US = 100;
    localparam int RST_PULSE_CYCLES = CLK_HZ / 1000000 * RST_PULSE_US;
    // Scan structure in line cycles
    localparam logic [3:0] SAMPLE_LINE_CYCLES = 4'h000B;
    localparam logic [3:0] CALC_LINE_CYCLES = 4'h0004;
    localparam logic [2:0] SCANS_PER_SECOND = 3'h4;
    localparam logic [9:0] SAMPLES_PER_PHASE = 10'h03C0;
    localparam logic [7:0] SAMPLES_PER_CHANNEL = 8'h00F0;
    localparam logic [2:0] TRIP_SAMPLE_COUNT = 3'h4;
    localparam int NUM_CURRENT_CH = 4;
    // Converter
    localparam int ADC_BITS = 10;
    localparam int ADC_MUX_BITS = 3;
    localparam int SUM_BITS = 18;
    // Nonvolatile store
    localparam int NV_DEPTH = 64;
    localparam int NV_ADDR_BITS = 6;
    localparam int NV_DATA_BITS = 8;
    localparam logic [5:0] NV_SNAP_BASE = 6'h0030;
    // Temperature sensor codes
    localparam logic [9:0] RTD_OPEN_CODE = 10'h03F0;
    localparam logic [9:0] RTD_SHORT_CODE = 10'h0010;
    // Register addresses of the plain register port
    localparam logic [7:0] ADDR_CTRL = 8'h0000;
    localparam logic [7:0] ADDR_STATUS = 8'h0004;
    localparam logic [7:0] ADDR_THR_BASE = 8'h0010;
    localparam logic [7:0] ADDR_SUM_BASE = 8'h0020;
    localparam logic [7:0] ADDR_TEMP = 8'h0030;
    localparam logic [7:0] ADDR_AOUT = 8'h0034;
    localparam logic [7:0] ADDR_NV_BASE = 8'h0040;
    // Control register fields
    localparam int CTRL_KICK_BIT = 0;
    localparam int CTRL_THERM_BIT = 1;
    localparam int CTRL_NICKEL_BIT = 2;
    localparam int CTRL_RTD_EN_BIT = 3;
    localparam int CTRL_TRIP_REQ_BIT = 4;
    localparam int CTRL_ALARM_REQ_BIT = 5;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mps_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [ADC_BITS-1:0] data;
    } mps_adc_t;

    typedef enum logic [1:0] {
        WD_RUN,
        WD_RESET,
        WD_WAIT,
        WD_LOCK
    } mps_wd_state_t;
endpackage : mps_pkg

// File: src/mps_top.sv
// Scan sequencer, instantaneous trip check, processor watchdog, lockout, power-fail save and NV store.
// Assumes a line-cycle strobe, a converter that returns one sample per start, and a processor on the register port.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module mps_top (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Line timing and supply pins
    input wire logic i_line_cycle,
    input wire logic i_supply_above_hi,
    input wire logic i_supply_above_lo,
    input wire logic i_prog_enable,
    input wire logic i_cpu_in_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Converter
    output logic o_adc_start,
    output logic [2:0] o_adc_mux,
    input wire logic i_adc_valid,
    input wire logic [9:0] i_adc_data,
    // Outputs
    output logic o_cpu_reset,
    output logic o_pfail_irq,
    output logic o_run_led,
    output logic o_trip_relay,
    output logic o_alarm_relay,
    output logic o_calc_phase,
    output logic o_iso_clk,
    output logic o_iso_data
);
    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins
    logic [1:0] line_s_r, hi_s_r, lo_s_r, pe_s_r, cr_s_r;
    logic line_d_r;
    logic line_tick;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            line_s_r <= 2'h0;
            hi_s_r <= 2'h0;
            lo_s_r <= 2'h0;
            pe_s_r <= 2'h0;
            cr_s_r <= 2'h0;
            line_d_r <= 1'b0;
        end else begin
            line_s_r <= {line_s_r[0], i_line_cycle};
            hi_s_r <= {hi_s_r[0], i_supply_above_hi};
            lo_s_r <= {lo_s_r[0], i_supply_above_lo};
            pe_s_r <= {pe_s_r[0], i_prog_enable};
            cr_s_r <= {cr_s_r[0], i_cpu_in_reset};
            line_d_r <= line_s_r[1];
        end
    end
    assign line_tick = line_s_r[1] & ~line_d_r;

    mps_pkg::mps_bus_req_t req;
    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    ////////////////////////////////////////////////////////////////////////////
    // Power good with hysteresis and power-fail save
    logic pgood_r, pfail_r, save_busy_r;
    logic [5:0] save_idx_r;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pgood_r <= 1'b0;
        end else if (hi_s_r[1]) begin
            pgood_r <= 1'b1;
        end else if (!lo_s_r[1]) begin
            pgood_r <= 1'b0;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pfail_r <= 1'b0;
            save_busy_r <= 1'b0;
            save_idx_r <= 6'h00;
        end else if (pgood_r && !lo_s_r[1]) begin
            pfail_r <= 1'b1;
            save_busy_r <= 1'b1;
            save_idx_r <= 6'h00;
        end else if (save_busy_r) begin
            save_idx_r <= save_idx_r + 6'h01;
            if (save_idx_r == 6'h0F) begin
                save_busy_r <= 1'b0;
            end
        end else if (pgood_r) begin
            pfail_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog and lockout
    localparam logic [23:0] WD_LIMIT = 24'(mps_pkg::WDOG_CYCLES - 1);
    localparam logic [23:0] RST_LIMIT = 24'(mps_pkg::RST_PULSE_CYCLES - 1);
    mps_pkg::mps_wd_state_t wd_state_r;
    logic [23:0] wd_cnt_r;
    logic nv_block_r, lock_r, cpu_rst_r;
    logic kick;
    assign kick = req.wr && req.addr == mps_pkg::ADDR_CTRL && req.wdata[mps_pkg::CTRL_KICK_BIT];
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wd_state_r <= mps_pkg::WD_RUN;
            wd_cnt_r <= 24'h0000;
            nv_block_r <= 1'b0;
            lock_r <= 1'b0;
            cpu_rst_r <= 1'b0;
        end else begin
            unique case (wd_state_r)
                mps_pkg::WD_RUN: begin
                    if (kick || !pgood_r) begin
                        wd_cnt_r <= 24'h0000;
                    end else if (wd_cnt_r == WD_LIMIT) begin
                        wd_state_r <= mps_pkg::WD_RESET;
                        wd_cnt_r <= 24'h0000;
                        cpu_rst_r <= 1'b1;
                        nv_block_r <= 1'b1;
                    end else begin
                        wd_cnt_r <= wd_cnt_r + 24'h0001;
                    end
                end
                mps_pkg::WD_RESET: begin
                    if (cr_s_r[1]) begin
                        wd_state_r <= mps_pkg::WD_WAIT;
                        nv_block_r <= 1'b0;
                    end else if (wd_cnt_r == RST_LIMIT) begin
                        wd_state_r <= mps_pkg::WD_LOCK;
                        lock_r <= 1'b1;
                    end else begin
                        wd_cnt_r <= wd_cnt_r + 24'h0001;
                    end
                end
                mps_pkg::WD_WAIT: begin
                    cpu_rst_r <= 1'b0;
                    wd_cnt_r <= 24'h0000;
                    if (!cr_s_r[1]) begin
                        wd_state_r <= mps_pkg::WD_RUN;
                    end
                end
                mps_pkg::WD_LOCK: begin
                    cpu_rst_r <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and threshold registers
    logic [5:0] ctrl_r;
    logic [9:0] thr_r [mps_pkg::NUM_CURRENT_CH];
    logic set_ok;
    assign set_ok = pe_s_r[1];
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_r <= 6'h00;
        end else if (req.wr && req.addr == mps_pkg::ADDR_CTRL && set_ok) begin
            ctrl_r <= req.wdata[5:0];
        end
    end
    genvar g;
    generate
        for (g = 0; g < mps_pkg::NUM_CURRENT_CH; g++) begin : g_thr
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    thr_r[g] <= 10'h03FF;
                end else if (req.wr && set_ok && req.addr == mps_pkg::ADDR_THR_BASE + 8'(4 * g)) begin
                    thr_r[g] <= req.wdata[9:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Scan sequencer
    logic [3:0] lc_cnt_r;
    logic calc_r;
    logic [2:0] scan_cnt_r;
    logic phase_start;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            lc_cnt_r <= 4'h0;
            calc_r <= 1'b1;
            scan_cnt_r <= 3'h0;
        end else if (line_tick && pgood_r && !lock_r) begin
            if (!calc_r && lc_cnt_r == mps_pkg::SAMPLE_LINE_CYCLES - 4'h1) begin
                calc_r <= 1'b1;
                lc_cnt_r <= 4'h0;
            end else if (calc_r && lc_cnt_r == mps_pkg::CALC_LINE_CYCLES - 4'h1) begin
                calc_r <= 1'b0;
                lc_cnt_r <= 4'h0;
                scan_cnt_r <= (scan_cnt_r == mps_pkg::SCANS_PER_SECOND - 3'h1) ? 3'h0 : scan_cnt_r + 3'h1;
            end else begin
                lc_cnt_r <= lc_cnt_r + 4'h1;
            end
        end
    end
    assign phase_start = line_tick && pgood_r && !lock_r && calc_r && lc_cnt_r == mps_pkg::CALC_LINE_CYCLES - 4'h1;

    // Sample pacing: 960 samples over 11 line cycles, so 960/11 per line cycle; spread by line-cycle timer
    logic [19:0] per_r, per_cnt_r;
    logic [23:0] pace_r, pace_lim;
    logic [9:0] samp_cnt_r;
    logic [1:0] ch_r;
    logic start_r, busy_r;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            per_r <= 20'h0_0000;
            per_cnt_r <= 20'h0_0000;
        end else if (line_tick) begin
            per_r <= per_cnt_r;
            per_cnt_r <= 20'h0_0000;
        end else if (per_cnt_r != 20'hF_FFFF) begin
            per_cnt_r <= per_cnt_r + 20'h0_0001;
        end
    end
    // Eleven measured line periods make one sampling phase
    assign pace_lim = 24'(per_r) * 24'(mps_pkg::SAMPLE_LINE_CYCLES);
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pace_r <= 24'h00_0000;
            samp_cnt_r <= 10'h000;
            ch_r <= 2'h0;
            start_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (phase_start) begin
                pace_r <= pace_lim;
                samp_cnt_r <= 10'h000;
                ch_r <= 2'h0;
                busy_r <= 1'b0;
            end else if (!calc_r && samp_cnt_r < mps_pkg::SAMPLES_PER_PHASE) begin
                // Credit 960 per clock against the phase length: one start every 1/960 of the phase
                if (pace_r >= pace_lim && !busy_r) begin
                    pace_r <= pace_r - pace_lim + 24'(mps_pkg::SAMPLES_PER_PHASE);
                    start_r <= 1'b1;
                    busy_r <= 1'b1;
                end else begin
                    pace_r <= pace_r + 24'(mps_pkg::SAMPLES_PER_PHASE);
                end
                if (i_adc_valid && busy_r) begin
                    busy_r <= 1'b0;
                    samp_cnt_r <= samp_cnt_r + 10'h001;
                    ch_r <= ch_r + 2'h1;
                end
            end else if (calc_r && !busy_r && line_tick) begin
                start_r <= 1'b1;
                busy_r <= 1'b1;
            end else if (i_adc_valid) begin
                busy_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Integration and instantaneous trip
    logic [17:0] sum_r [mps_pkg::NUM_CURRENT_CH];
    logic [2:0] over_r [mps_pkg::NUM_CURRENT_CH];
    logic [3:0] inst_hit;
    logic samp_in;
    assign samp_in = i_adc_valid && busy_r && !calc_r;
    generate
        for (g = 0; g < mps_pkg::NUM_CURRENT_CH; g++) begin : g_ch
            always_ff @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    sum_r[g] <= 18'h0_0000;
                    over_r[g] <= 3'h0;
                end else if (phase_start) begin
                    sum_r[g] <= 18'h0_0000;
                    over_r[g] <= 3'h0;
                end else if (samp_in && ch_r == 2'(g)) begin
                    sum_r[g] <= sum_r[g] + {8'h00, i_adc_data};
                    if (i_adc_data > thr_r[g] && over_r[g] != mps_pkg::TRIP_SAMPLE_COUNT) begin
                        over_r[g] <= over_r[g] + 3'h1;
                    end
                end
            end
            assign inst_hit[g] = over_r[g] == mps_pkg::TRIP_SAMPLE_COUNT;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Temperature check, linearisation and relay drive
    logic [9:0] temp_raw_r, temp_lin_r;
    logic sens_alarm_r, trip_r, alarm_r, calc_d_r;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            temp_raw_r <= 10'h000;
        end else if (i_adc_valid && busy_r && calc_r) begin
            temp_raw_r <= i_adc_data;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            temp_lin_r <= 10'h000;
            sens_alarm_r <= 1'b0;
            calc_d_r <= 1'b0;
        end else begin
            calc_d_r <= calc_r;
            if (calc_r && !calc_d_r) begin
                // Nickel curve: subtract a quadratic bow term
                temp_lin_r <= ctrl_r[mps_pkg::CTRL_NICKEL_BIT]
                    ? temp_raw_r - 10'(({10'h000, temp_raw_r} * {10'h000, temp_raw_r}) >> 12)
                    : temp_raw_r;
                sens_alarm_r <= ctrl_r[mps_pkg::CTRL_RTD_EN_BIT] && !ctrl_r[mps_pkg::CTRL_THERM_BIT]
                    && (temp_raw_r >= mps_pkg::RTD_OPEN_CODE || temp_raw_r <= mps_pkg::RTD_SHORT_CODE);
            end
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            trip_r <= 1'b0;
            alarm_r <= 1'b0;
        end else if (lock_r) begin
            trip_r <= 1'b0;
            alarm_r <= 1'b0;
        end else begin
            trip_r <= |inst_hit || (calc_r && ctrl_r[mps_pkg::CTRL_TRIP_REQ_BIT]);
            alarm_r <= sens_alarm_r || (calc_r && ctrl_r[mps_pkg::CTRL_ALARM_REQ_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Nonvolatile store
    logic [7:0] nv_mem_r [mps_pkg::NV_DEPTH];
    logic [7:0] aout_r;
    logic nv_wr;
    assign nv_wr = req.wr && req.addr[7:6] == 2'h1 && set_ok && !nv_block_r && pgood_r;
    always_ff @(posedge i_clk_sys) begin
        if (nv_wr) begin
            nv_mem_r[req.addr[5:0]] <= req.wdata[7:0];
        end else if (save_busy_r) begin
            nv_mem_r[mps_pkg::NV_SNAP_BASE + save_idx_r[3:0]] <= sum_r[save_idx_r[1:0]][17:10];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Isolated output serial stream
    logic [7:0] sh_r;
    logic [3:0] bit_r;
    logic isoc_r;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            aout_r <= 8'h00;
            sh_r <= 8'h00;
            bit_r <= 4'h0;
            isoc_r <= 1'b0;
        end else begin
            if (req.wr && req.addr == mps_pkg::ADDR_AOUT) begin
                aout_r <= req.wdata[7:0];
            end
            if (line_tick) begin
                if (bit_r == 4'h0) begin
                    sh_r <= aout_r;
                    bit_r <= 4'h8;
                    isoc_r <= 1'b0;
                end else begin
                    isoc_r <= ~isoc_r;
                    if (isoc_r) begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        bit_r <= bit_r - 4'h1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and output registers
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            if (req.addr == mps_pkg::ADDR_CTRL) begin
                o_rdata <= {26'h000_0000, ctrl_r};
            end else if (req.addr == mps_pkg::ADDR_STATUS) begin
                o_rdata <= {21'h00_0000, scan_cnt_r, calc_r, |inst_hit, sens_alarm_r, pfail_r,
                            pgood_r, nv_block_r, lock_r, pe_s_r[1]};
            end else if (req.addr[7:4] == 4'h1) begin
                o_rdata <= {22'h00_0000, thr_r[req.addr[3:2]]};
            end else if (req.addr[7:4] == 4'h2) begin
                o_rdata <= {14'h0000, sum_r[req.addr[3:2]]};
            end else if (req.addr == mps_pkg::ADDR_TEMP) begin
                o_rdata <= {22'h00_0000, temp_lin_r};
            end else if (req.addr[7:6] == 2'h1) begin
                o_rdata <= {24'h00_0000, nv_mem_r[req.addr[5:0]]};
            end else begin
                o_rdata <= 32'h0000_0000;
            end
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_adc_start <= 1'b0;
            o_adc_mux <= 3'h0;
            o_cpu_reset <= 1'b1;
            o_pfail_irq <= 1'b0;
            o_run_led <= 1'b0;
            o_trip_relay <= 1'b0;
            o_alarm_relay <= 1'b0;
            o_calc_phase <= 1'b1;
            o_iso_clk <= 1'b0;
            o_iso_data <= 1'b0;
        end else begin
            o_adc_start <= start_r;
            o_adc_mux <= calc_r ? 3'h4 : {1'b0, ch_r};
            o_cpu_reset <= cpu_rst_r || !pgood_r;
            o_pfail_irq <= pfail_r;
            o_run_led <= !lock_r && pgood_r;
            o_trip_relay <= trip_r && !lock_r;
            o_alarm_relay <= alarm_r && !lock_r;
            o_calc_phase <= calc_r;
            o_iso_clk <= isoc_r;
            o_iso_data <= sh_r[7];
        end
    end
endmodule : mps_top

// File: tb/mps_adc_model.sv
// Converter model: one conversion per start, answer after a set latency.
// Assumes starts only when no conversion is outstanding.
`timescale 1ns/10ps
module mps_adc_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Converter port
    input wire logic i_start,
    input wire logic [2:0] i_mux,
    output logic o_valid,
    output logic [9:0] o_data,
    // Levels and pacing from the bench
    input wire logic [9:0] i_cur,
    input wire logic [9:0] i_temp,
    input wire logic [3:0] i_lat
);
    logic busy_r;
    logic [3:0] cnt_r;
    logic [2:0] ch_r;
    // Data lines toggle outside the answer cycle
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            ch_r <= 3'h0;
            o_valid <= 1'b0;
            o_data <= 10'h000;
        end else begin
            o_valid <= busy_r && cnt_r == 4'h0;
            o_data <= (busy_r && cnt_r == 4'h0) ? ((ch_r < 3'h4) ? i_cur : i_temp) : ~o_data;
            if (i_start) begin
                busy_r <= 1'b1;
                cnt_r <= i_lat;
                ch_r <= i_mux;
            end else if (busy_r) begin
                busy_r <= cnt_r != 4'h0;
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule : mps_adc_model

// File: tb/mps_top_props.sv
// Port checks for the scan block.
// Assumes one clock and async active-low reset.
`timescale 1ns/10ps
module mps_top_props (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Watched ports
    input wire logic i_line_cycle,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_adc_start,
    input wire logic [2:0] o_adc_mux,
    input wire logic i_adc_valid,
    input wire logic o_calc_phase
);
    logic busy_r, lc_r, calc_r, seen_r;
    logic [3:0] edges_r;
    logic [9:0] vcnt_r;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    // Line edges and samples per phase, conversion in flight
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_r <= 1'b0;
            lc_r <= 1'b0;
            calc_r <= 1'b1;
            seen_r <= 1'b0;
            edges_r <= 4'h0;
            vcnt_r <= 10'h000;
        end else begin
            busy_r <= o_adc_start || (busy_r && !i_adc_valid);
            lc_r <= i_line_cycle;
            calc_r <= o_calc_phase;
            if (o_calc_phase != calc_r) begin
                seen_r <= 1'b1;
                edges_r <= 4'h0;
                vcnt_r <= 10'h000;
            end else begin
                edges_r <= edges_r + {3'h0, i_line_cycle && !lc_r};
                vcnt_r <= vcnt_r + {9'h000, i_adc_valid};
            end
        end
    end
    sequence phase_end;
        seen_r && o_calc_phase != calc_r;
    endsequence
    one_conv_a: assert property (o_adc_start |-> !busy_r)
        else $error("second start in flight");
    mux_range_a: assert property (o_adc_start |-> o_adc_mux <= 3'h4)
        else $error("bad channel");
    calc_mux_a: assert property (o_calc_phase && $past(o_calc_phase) && o_adc_start |-> o_adc_mux == 3'h4)
        else $error("current sample in calc phase");
    calc_len_a: assert property (phase_end and calc_r |-> edges_r == 4'h4)
        else $error("calc phase length");
    samp_len_a: assert property (phase_end and !calc_r |-> edges_r == 4'hB)
        else $error("sampling phase length");
    samples_a: assert property (phase_end and !calc_r |-> vcnt_r == mps_pkg::SAMPLES_PER_PHASE)
        else $error("too few samples");
    unmapped_a: assert property (i_rd && i_addr == 8'h08 |=> o_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    status_calc_a: assert property (i_rd && i_addr == mps_pkg::ADDR_STATUS |=> o_rdata[7] == o_calc_phase)
        else $error("status calc bit");
endmodule : mps_top_props

// File: tb/tb_top.sv
// Bench: line, supply, keylock, converter model and register reads.
// Assumes mps_pkg and the model are compiled first.
`timescale 1ns/10ps
module tb_top;
    logic i_clk_sys, i_resetn, i_line_cycle, i_supply_above_hi, i_supply_above_lo, i_prog_enable;
    logic i_cpu_in_reset, i_wr, i_rd, i_adc_valid, o_adc_start, o_cpu_reset, o_pfail_irq, o_run_led;
    logic o_trip_relay, o_alarm_relay, o_calc_phase, o_iso_clk, o_iso_data;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [2:0] o_adc_mux;
    logic [9:0] i_adc_data, cur, temp;
    logic [3:0] lat;
    int errors, checked;
    mps_top DUT (.i_clk_sys, .i_resetn, .i_line_cycle, .i_supply_above_hi, .i_supply_above_lo,
        .i_prog_enable, .i_cpu_in_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_adc_start,
        .o_adc_mux, .i_adc_valid, .i_adc_data, .o_cpu_reset, .o_pfail_irq, .o_run_led,
        .o_trip_relay, .o_alarm_relay, .o_calc_phase, .o_iso_clk, .o_iso_data);
    mps_adc_model u_adc (.i_clk_sys, .i_resetn, .i_start(o_adc_start), .i_mux(o_adc_mux),
        .o_valid(i_adc_valid), .o_data(i_adc_data), .i_cur(cur), .i_temp(temp), .i_lat(lat));
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    always begin
        repeat (400) @(posedge i_clk_sys);
        i_line_cycle <= ~i_line_cycle;
    end
    task automatic test_done;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task automatic wait_for(input logic sel, input logic v);
        int n;
        n = 0;
        while ((sel ? o_pfail_irq : o_calc_phase) !== v) begin
            @(posedge i_clk_sys);
            n++;
            if (n > 10000) begin
                errors++;
                test_done();
            end
        end
    endtask : wait_for
    task automatic scan;
        wait_for(1'b0, 1'b0);
        wait_for(1'b0, 1'b1);
    endtask : scan
    initial begin
        {i_resetn, i_line_cycle, i_prog_enable, i_cpu_in_reset, i_wr, i_rd} = 6'h00;
        {i_supply_above_hi, i_supply_above_lo} = 2'h3;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        {cur, temp, lat} = {10'h040, 10'h200, 4'h0};
        {errors, checked} = {32'h0000_0000, 32'h0000_0000};
        repeat (20) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd(8'h08);
        cmp(d, 32'h0000_0000);
        wr(mps_pkg::ADDR_THR_BASE, 32'h0000_0100);
        rd(mps_pkg::ADDR_THR_BASE);
        cmp(d, 32'h0000_03FF);
        i_prog_enable <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        wr(mps_pkg::ADDR_THR_BASE, 32'h0000_0100);
        rd(mps_pkg::ADDR_THR_BASE);
        cmp(d, 32'h0000_0100);
        wr(8'h41, 32'h0000_005A);
        wr(8'h7F, 32'h0000_00A5);
        rd(8'h7F);
        cmp(d, 32'h0000_00A5);
        wr(mps_pkg::ADDR_CTRL, 32'h0000_000A);
        temp <= mps_pkg::RTD_OPEN_CODE;
        scan();
        lat <= 4'h3;
        scan();
        rd(mps_pkg::ADDR_STATUS);
        cmp(d & 32'h0000_0060, 32'h0000_0000);
        rd(mps_pkg::ADDR_SUM_BASE);
        cmp(d, 32'h0000_3C00);
        wr(mps_pkg::ADDR_CTRL, 32'h0000_0008);
        cur <= 10'h200;
        scan();
        scan();
        rd(mps_pkg::ADDR_STATUS);
        cmp(d & 32'h0000_0060, 32'h0000_0060);
        cmp({30'h0, o_trip_relay, o_alarm_relay}, 32'h0000_0003);
        {i_supply_above_hi, i_supply_above_lo} <= 2'h0;
        wait_for(1'b1, 1'b1);
        rd(mps_pkg::ADDR_STATUS);
        cmp(d & 32'h0000_0018, 32'h0000_0010);
        rd(8'h70);
        cmp(d, 32'h0000_0078);
        wr(8'h41, 32'h0000_0011);
        i_supply_above_lo <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        rd(mps_pkg::ADDR_STATUS);
        cmp(d & 32'h0000_0008, 32'h0000_0000);
        cmp({31'h0, o_cpu_reset}, 32'h0000_0001);
        i_supply_above_hi <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        rd(mps_pkg::ADDR_STATUS);
        cmp(d & 32'h0000_0008, 32'h0000_0008);
        cmp({30'h0, o_run_led, o_cpu_reset}, 32'h0000_0002);
        rd(8'h41);
        cmp(d, 32'h0000_005A);
        test_done();
    end
endmodule : tb_top
bind mps_top mps_top_props u_props (.i_clk_sys, .i_resetn, .i_line_cycle, .i_addr, .i_rd, .o_rdata,
    .o_adc_start, .o_adc_mux, .i_adc_valid, .o_calc_phase);
